// [hw/hspus_pkg.sv]
package hspus_pkg;
	// Serial-port selection after reset.
	typedef enum logic [3:0]
	{
		HSPUS_PORT_BOOT  = 4'h1,
		HSPUS_PORT_UART  = 4'h2,
		HSPUS_PORT_SPI   = 4'h4,
		HSPUS_PORT_EITHER = 4'h8
	} hspus_port_type;

	// UART transmit states.
	typedef enum logic [4:0]
	{
		HSPUS_TX_IDLE   = 5'h01,
		HSPUS_TX_START  = 5'h02,
		HSPUS_TX_DATA   = 5'h04,
		HSPUS_TX_PARITY = 5'h08,
		HSPUS_TX_STOP   = 5'h10
	} hspus_tx_type;

	// UART line configuration.
	typedef struct packed
	{
		logic [15:0] baud_rate_setting;
		logic [1:0]  parity_setting;
		logic        stop_bits_setting;
	} hspus_uart_cfg_type;

	// Pin function settings touched by forced SPI entry.
	typedef struct packed
	{
		logic [3:0] attention_pin_function;
		logic [3:0] clock_pin_function;
		logic [3:0] select_pin_function;
		logic [3:0] data_in_pin_function;
		logic [3:0] data_out_pin_function;
	} hspus_pins_type;

	localparam int          HSPUS_CLK_HZ        = 100000000;
	localparam int          HSPUS_RECOVERY_BAUD = 9600;
	localparam logic [15:0] HSPUS_RECOVERY_DIV  = 16'(HSPUS_CLK_HZ / HSPUS_RECOVERY_BAUD);
	localparam logic [1:0]  HSPUS_PARITY_NONE   = 2'h0;
	localparam logic [1:0]  HSPUS_PARITY_EVEN   = 2'h1;
	localparam logic [1:0]  HSPUS_PARITY_ODD    = 2'h2;
	localparam logic [3:0]  HSPUS_FUNC_DEFAULT  = 4'h0;
	localparam logic [3:0]  HSPUS_FUNC_SPI      = 4'h1;
	localparam logic        HSPUS_API_SPI       = 1'h1;
	localparam int          HSPUS_DATA_BITS     = 8;
endpackage : hspus_pkg

// [hw/hspus_port.sv]
`timescale 1ns/1ps
// Overview of operation
// - UART: start low, 8 LSB-first, stop high.
// - Baud, parity, stop bits are configurable.
// - Input low at reset, output high: UART 9600 command.
// - Saved UART enable persists across resets.
// - SPI port is slave only.
// - Attention asserted while output data queued.
// - SPI mode 0, MSB first.
// - SPI always uses API framing.
// - Output low at reset forces SPI mode.
// - Forced SPI sets pin functions; attention conditionally.
// - Forced settings revert unless saved.
// - Stored SPI-only config boots SPI.
// - Both enabled: first input picks port.
// - SPI active only while select asserted.
// - Select rising edge releases data-out.
// - Empty queue repeats last valid bit.
// - SPI output sent as API frames.
// - Names ending _n are active low.
module hspus_port
	import hspus_pkg::*;
(
	// Clocks and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	// Stored configuration and save command
	input  wire hspus_uart_cfg_type stored_uart_cfg,
	input  wire hspus_pins_type     stored_pins,
	input  wire logic               stored_uart_enable,
	input  wire logic               stored_spi_enable,
	input  wire logic               save_to_flash_command,
	input  wire logic               power_on_reset,
	output hspus_pins_type          active_pins,
	output logic                    save_pins_strobe,
	output logic                    command_mode,
	output logic                    api_framing_setting,
	output hspus_port_type          port_state,
	// Outgoing byte stream from the core
	input  wire logic [7:0]         tx_data,
	input  wire logic               tx_valid,
	input  wire logic               tx_last,
	output logic                    tx_ready,
	// Incoming bytes to the core
	output logic [7:0]              rx_data,
	output logic                    rx_valid,
	// UART pins
	input  wire logic               uart_din,
	output logic                    uart_dout_o,
	output logic                    uart_dout_oe,
	input  wire logic               uart_dout_i,
	// SPI pins
	input  wire logic               spi_sclk,
	input  wire logic               slave_select_n,
	input  wire logic               spi_mosi,
	output logic                    spi_miso_o,
	output logic                    spi_miso_oe,
	output logic                    host_attention_n
);
	if (HSPUS_DATA_BITS != 8)
	begin : g_width_check
		$error("Only eight-bit characters are supported.");
	end

	// Three-stage synchronisers for pins; stage 2 and 3 must agree.
	logic [2:0] din_sync, dout_sync;
	logic       din_lvl, dout_lvl;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_sync  <= 3'h7;
			dout_sync <= 3'h7;
		end
		else if (clk_en)
		begin
			din_sync  <= {din_sync[1:0], uart_din};
			dout_sync <= {dout_sync[1:0], uart_dout_i};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			din_lvl  <= 1'h1;
			dout_lvl <= 1'h1;
		end
		else if (clk_en)
		begin
			if (din_sync[1] == din_sync[2])
				din_lvl <= din_sync[2];
			if (dout_sync[1] == dout_sync[2])
				dout_lvl <= dout_sync[2];
		end
	end

	// Boot decision, taken once the straps have settled after reset.
	logic [3:0]         boot_cnt;
	logic               forced_spi;
	logic               saved_force;
	hspus_uart_cfg_type uart_cfg;
	logic               spi_rx_event, uart_rx_event;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			boot_cnt     <= 4'h0;
			port_state   <= HSPUS_PORT_BOOT;
			forced_spi   <= 1'h0;
			command_mode <= 1'h0;
			uart_cfg     <= '0;
		end
		else if (clk_en)
		begin
			case (port_state)
				HSPUS_PORT_BOOT:
				begin
					boot_cnt <= boot_cnt + 4'h1;
					if (boot_cnt == 4'hF)
					begin
						uart_cfg <= stored_uart_cfg;
						if (!dout_lvl)
						begin
							forced_spi <= 1'h1;
							port_state <= HSPUS_PORT_SPI;
						end
						else if (!din_lvl)
						begin
							uart_cfg     <= '{HSPUS_RECOVERY_DIV, HSPUS_PARITY_NONE, 1'h0};
							command_mode <= 1'h1;
							port_state   <= HSPUS_PORT_UART;
						end
						else if (stored_uart_enable && stored_spi_enable)
							port_state <= HSPUS_PORT_EITHER;
						else if (stored_spi_enable)
							port_state <= HSPUS_PORT_SPI;
						else
							port_state <= HSPUS_PORT_UART;
					end
				end
				HSPUS_PORT_EITHER:
				begin
					if (spi_rx_event)
						port_state <= HSPUS_PORT_SPI;
					else if (uart_rx_event)
						port_state <= HSPUS_PORT_UART;
				end
				HSPUS_PORT_UART, HSPUS_PORT_SPI:
					port_state <= port_state;
				default:
					port_state <= HSPUS_PORT_BOOT;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			saved_force      <= 1'h0;
			save_pins_strobe <= 1'h0;
		end
		else if (clk_en)
		begin
			save_pins_strobe <= forced_spi && save_to_flash_command && (port_state == HSPUS_PORT_SPI);
			if (save_pins_strobe)
				saved_force <= 1'h1;
			else if (power_on_reset)
				saved_force <= 1'h0;
		end
	end

	always_comb
	begin
		active_pins = stored_pins;
		if (forced_spi)
		begin
			active_pins.clock_pin_function    = HSPUS_FUNC_SPI;
			active_pins.select_pin_function   = HSPUS_FUNC_SPI;
			active_pins.data_in_pin_function  = HSPUS_FUNC_SPI;
			active_pins.data_out_pin_function = HSPUS_FUNC_SPI;
			if (stored_pins.attention_pin_function == HSPUS_FUNC_DEFAULT)
				active_pins.attention_pin_function = HSPUS_FUNC_SPI;
		end
	end

	logic uart_out, spi_out;
	assign uart_out            = port_state inside {HSPUS_PORT_UART, HSPUS_PORT_EITHER};
	assign spi_out             = (port_state == HSPUS_PORT_SPI);
	assign api_framing_setting = spi_out ? HSPUS_API_SPI : 1'h0;

	// UART transmitter.
	hspus_tx_type tx_state;
	logic [15:0]  baud_cnt;
	logic [7:0]   tx_shift;
	logic [2:0]   bit_idx;
	logic         stop_two, tx_par;
	logic         uart_take;
	assign uart_take = uart_out && (tx_state == HSPUS_TX_IDLE) && tx_valid;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state    <= HSPUS_TX_IDLE;
			baud_cnt    <= 16'h0;
			tx_shift    <= 8'h0;
			bit_idx     <= 3'h0;
			stop_two    <= 1'h0;
			tx_par      <= 1'h0;
			uart_dout_o <= 1'h1;
		end
		else if (clk_en)
		begin
			if (tx_state != HSPUS_TX_IDLE)
				baud_cnt <= (baud_cnt == 16'h0) ? uart_cfg.baud_rate_setting - 16'h1 : baud_cnt - 16'h1;
			case (tx_state)
				HSPUS_TX_IDLE:
				begin
					uart_dout_o <= 1'h1;
					if (uart_take)
					begin
						tx_shift    <= tx_data;
						tx_par      <= ^tx_data ^ (uart_cfg.parity_setting == HSPUS_PARITY_ODD);
						bit_idx     <= 3'h0;
						stop_two    <= uart_cfg.stop_bits_setting;
						baud_cnt    <= uart_cfg.baud_rate_setting - 16'h1;
						uart_dout_o <= 1'h0;
						tx_state    <= HSPUS_TX_START;
					end
				end
				HSPUS_TX_START:
					if (baud_cnt == 16'h0)
					begin
						uart_dout_o <= tx_shift[0];
						tx_state    <= HSPUS_TX_DATA;
					end
				HSPUS_TX_DATA:
					if (baud_cnt == 16'h0)
					begin
						tx_shift <= {1'h0, tx_shift[7:1]};
						bit_idx  <= bit_idx + 3'h1;
						if (bit_idx != 3'h7)
							uart_dout_o <= tx_shift[1];
						else if (uart_cfg.parity_setting != HSPUS_PARITY_NONE)
						begin
							uart_dout_o <= tx_par;
							tx_state    <= HSPUS_TX_PARITY;
						end
						else
						begin
							uart_dout_o <= 1'h1;
							tx_state    <= HSPUS_TX_STOP;
						end
					end
				HSPUS_TX_PARITY:
					if (baud_cnt == 16'h0)
					begin
						uart_dout_o <= 1'h1;
						tx_state    <= HSPUS_TX_STOP;
					end
				HSPUS_TX_STOP:
					if (baud_cnt == 16'h0)
					begin
						if (stop_two)
							stop_two <= 1'h0;
						else
							tx_state <= HSPUS_TX_IDLE;
					end
				default:
					tx_state <= HSPUS_TX_IDLE;
			endcase
		end
	end
	// The strap on the output pin is read before the line is driven.
	assign uart_dout_oe = uart_out && (port_state != HSPUS_PORT_BOOT);

	// UART receiver: times a character from the start edge, samples mid-bit, flags it at a high stop bit.
	logic [15:0] rx_cnt;
	logic [3:0]  rx_bits;
	logic [7:0]  rx_shift;
	logic        din_prev;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_cnt        <= 16'h0;
			rx_bits       <= 4'h0;
			rx_shift      <= 8'h0;
			din_prev      <= 1'h1;
			uart_rx_event <= 1'h0;
		end
		else if (clk_en)
		begin
			din_prev      <= din_lvl;
			uart_rx_event <= 1'h0;
			if (rx_bits == 4'h0)
			begin
				if (din_prev && !din_lvl && uart_out)
				begin
					rx_bits <= (uart_cfg.parity_setting != HSPUS_PARITY_NONE) ? 4'hA : 4'h9;
					rx_cnt  <= uart_cfg.baud_rate_setting + (uart_cfg.baud_rate_setting >> 1);
				end
			end
			else if (rx_cnt == 16'h0)
			begin
				// Reload one short so each bit lasts exactly one divisor.
				rx_cnt  <= uart_cfg.baud_rate_setting - 16'h1;
				rx_bits <= rx_bits - 4'h1;
				if (rx_bits == 4'h1)
					uart_rx_event <= din_lvl;
				else if (!(rx_bits == 4'h2 && uart_cfg.parity_setting != HSPUS_PARITY_NONE))
					rx_shift <= {din_lvl, rx_shift[7:1]};
			end
			else
				rx_cnt <= rx_cnt - 16'h1;
		end
	end

	// SPI link domain, clocked by the master's serial clock.
	logic [7:0] spi_tx_byte;
	logic       spi_tx_full;
	logic [7:0] miso_hold;
	logic       miso_real;
	logic [2:0] miso_idx;
	logic       miso_last;
	logic       miso_cur;
	logic [7:0] mosi_shift;
	logic [2:0] mosi_cnt;
	logic       byte_tgl_s, take_tgl_s;
	logic [7:0] mosi_byte;
	// Bit counters restart whenever the master deselects.
	always_ff @(posedge spi_sclk or posedge slave_select_n or negedge rst_n)
	begin
		if (!rst_n)
			mosi_cnt <= 3'h0;
		else if (slave_select_n)
			mosi_cnt <= 3'h0;
		else
			mosi_cnt <= mosi_cnt + 3'h1;
	end
	always_ff @(posedge spi_sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mosi_shift <= 8'h0;
			mosi_byte  <= 8'h0;
			byte_tgl_s <= 1'h0;
		end
		else if (!slave_select_n)
		begin
			mosi_shift <= {mosi_shift[6:0], spi_mosi};
			if (mosi_cnt == 3'h7)
			begin
				mosi_byte  <= {mosi_shift[6:0], spi_mosi};
				byte_tgl_s <= ~byte_tgl_s;
			end
		end
	end
	always_ff @(negedge spi_sclk or posedge slave_select_n or negedge rst_n)
	begin
		if (!rst_n)
			miso_idx <= 3'h7;
		else if (slave_select_n)
			miso_idx <= 3'h7;
		else
			miso_idx <= miso_idx - 3'h1;
	end
	assign miso_cur = (miso_idx == 3'h7) ? (spi_tx_full ? spi_tx_byte[7] : miso_last) : miso_hold[miso_idx];
	always_ff @(negedge spi_sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			miso_hold  <= 8'h0;
			miso_real  <= 1'h0;
			miso_last  <= 1'h0;
			take_tgl_s <= 1'h0;
		end
		else if (!slave_select_n)
		begin
			miso_last <= miso_cur;
			if (miso_idx == 3'h7)
			begin
				miso_hold <= spi_tx_full ? spi_tx_byte : {8{miso_last}};
				miso_real <= spi_tx_full;
			end
			if (miso_idx == 3'h0 && miso_real)
				take_tgl_s <= ~take_tgl_s;
		end
	end
	assign spi_miso_o  = spi_out && miso_cur;
	assign spi_miso_oe = spi_out && !slave_select_n;

	// Crossings back into the system clock.
	logic [2:0] byte_tgl_c, take_tgl_c;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			byte_tgl_c <= 3'h0;
			take_tgl_c <= 3'h0;
		end
		else if (clk_en)
		begin
			byte_tgl_c <= {byte_tgl_c[1:0], byte_tgl_s};
			take_tgl_c <= {take_tgl_c[1:0], take_tgl_s};
		end
	end
	assign spi_rx_event = (byte_tgl_c[2] != byte_tgl_c[1]) && (port_state != HSPUS_PORT_UART);

	logic frame_open;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			spi_tx_full <= 1'h0;
			spi_tx_byte <= 8'h0;
			frame_open  <= 1'h0;
			rx_data     <= 8'h0;
			rx_valid    <= 1'h0;
		end
		else if (clk_en)
		begin
			rx_valid <= spi_rx_event || uart_rx_event;
			if (spi_rx_event)
				rx_data <= mosi_byte;
			else if (uart_rx_event)
				rx_data <= rx_shift;
			if (take_tgl_c[2] != take_tgl_c[1])
				spi_tx_full <= 1'h0;
			else if (spi_out && !spi_tx_full && tx_valid)
			begin
				spi_tx_full <= 1'h1;
				spi_tx_byte <= tx_data;
				frame_open  <= !tx_last;
			end
		end
	end
	assign tx_ready         = uart_take || (spi_out && !spi_tx_full);
	assign host_attention_n = !(spi_out && (spi_tx_full || frame_open || tx_valid));

	AST_ATTN_FOLLOWS_QUEUE: assert property (@(posedge clk) disable iff (!rst_n)
		spi_out && spi_tx_full |-> !host_attention_n) else $error("Attention idle with data queued.");
	AST_MISO_RELEASED: assert property (@(posedge clk) disable iff (!rst_n)
		slave_select_n |-> !spi_miso_oe) else $error("Data-out driven while deselected.");
	AST_UART_START_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && uart_take |=> !uart_dout_o) else $error("Start bit not low.");
	AST_IDLE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
		tx_state == HSPUS_TX_IDLE && $past(tx_state) == HSPUS_TX_IDLE |-> uart_dout_o) else $error("Line not idle high.");
	AST_API_ON_SPI: assert property (@(posedge clk) disable iff (!rst_n)
		spi_out |-> api_framing_setting) else $error("SPI without framing.");
	AST_FORCED_PINS: assert property (@(posedge clk) disable iff (!rst_n)
		forced_spi |-> active_pins.clock_pin_function == HSPUS_FUNC_SPI) else $error("Forced pins not set.");
	AST_PORT_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
		port_state == HSPUS_PORT_SPI |=> port_state == HSPUS_PORT_SPI) else $error("Port left SPI.");
	AST_UART_QUIET_SPI: assert property (@(posedge clk) disable iff (!rst_n)
		spi_out |-> !uart_dout_oe) else $error("UART driven in SPI mode.");
	COV_SPI_FORCED: cover property (@(posedge clk) disable iff (!rst_n) forced_spi);
	COV_RECOVERY: cover property (@(posedge clk) disable iff (!rst_n) command_mode);
	COV_PICK_SPI: cover property (@(posedge clk) disable iff (!rst_n)
		port_state == HSPUS_PORT_EITHER ##1 port_state == HSPUS_PORT_SPI);
endmodule : hspus_port

// [testbench/hspus_host_model.sv]
`timescale 1ns/1ps
module hspus_host_model
(
	// Bit timing
	input  wire logic clk,
	// UART lines
	output logic      uart_din,
	input  wire logic uart_line,
	// SPI lines
	output logic      spi_sclk,
	output logic      slave_select_n,
	output logic      spi_mosi,
	input  wire logic miso_line
);
	initial
	begin
		uart_din = 1'h1;
		spi_sclk = 1'h0;
		slave_select_n = 1'h1;
		spi_mosi = 1'h0;
	end

	task automatic set_din(input logic v);
		@(posedge clk);
		uart_din <= v;
	endtask : set_din

	task automatic uart_send(input logic [7:0] b, input int div);
		logic [9:0] fr;
		fr = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk);
			uart_din <= fr[i];
			repeat (div - 1) @(posedge clk);
		end
	endtask : uart_send

	task automatic wait_low(output logic seen);
		seen = 1'h0;
		for (int n = 0; n < 400 && !seen; n++)
		begin
			@(posedge clk);
			seen = (uart_line === 1'h0);
		end
	endtask : wait_low

	task automatic uart_recv(output logic [7:0] b, output logic ok, input int div);
		wait_low(ok);
		repeat (div / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (div) @(posedge clk);
			b[i] = uart_line;
		end
		repeat (div) @(posedge clk);
		ok = ok & (uart_line === 1'h1);
	endtask : uart_recv

	// Counts the clock edges that see the start bit low.
	task automatic low_span(output int n);
		logic seen;
		wait_low(seen);
		n = seen ? 1 : 0;
		while (seen && n < 20000)
		begin
			@(posedge clk);
			if (uart_line !== 1'h0)
				break;
			n++;
		end
	endtask : low_span

	task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
		slave_select_n = 1'h0;
		#50;
		for (int i = 7; i >= 0; i--)
		begin
			spi_mosi = tx[i];
			#3;
			spi_sclk = 1'h1;
			rx[i] = miso_line;
			#3;
			spi_sclk = 1'h0;
		end
		#50;
		slave_select_n = 1'h1;
		// A released data line carries no stale bit.
		spi_mosi = ~spi_mosi;
	endtask : spi_xfer
endmodule : hspus_host_model

// [testbench/hspus_port_tb.sv]
`timescale 1ns/1ps
module hspus_port_tb
	import hspus_pkg::*;
;
	logic               clk = 1'h0;
	// Starts high so the first reset is a real falling edge.
	logic               rst_n = 1'h1;
	logic               uen = 1'h1;
	logic               sen = 1'h0;
	logic               save = 1'h0;
	logic               dout_strap = 1'h0;
	logic               miso_float = 1'h0;
	logic [7:0]         tx_data = 8'h00;
	logic               tx_valid = 1'h0;
	logic               tx_last = 1'h0;
	hspus_uart_cfg_type cfg = '{16'h0010, HSPUS_PARITY_NONE, 1'h0};
	hspus_pins_type     pins = '{4'h0, 4'h3, 4'h3, 4'h3, 4'h3};
	hspus_pins_type     active_pins;
	hspus_port_type     port_state;
	logic [7:0]         rx_data;
	logic               strobe, cmd, api, tx_ready, rx_valid, dout_o, dout_oe;
	logic               miso_o, miso_oe, attn_n, din, sclk, ssel_n, mosi;
	wire                uart_line = dout_oe ? dout_o : ~dout_strap;
	wire                miso_line = miso_oe ? miso_o : miso_float;
	int                 err_count = 0;
	int                 check_count = 0;

	always #5 clk = ~clk;
	always @(posedge clk) miso_float <= ~miso_float;

	hspus_port hspus_port_i (.clk(clk), .rst_n(rst_n), .clk_en(1'h1), .stored_uart_cfg(cfg), .stored_pins(pins),
		.stored_uart_enable(uen), .stored_spi_enable(sen), .save_to_flash_command(save), .power_on_reset(1'h0),
		.active_pins(active_pins), .save_pins_strobe(strobe), .command_mode(cmd), .api_framing_setting(api),
		.port_state(port_state), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.rx_data(rx_data), .rx_valid(rx_valid), .uart_din(din), .uart_dout_o(dout_o), .uart_dout_oe(dout_oe),
		.uart_dout_i(uart_line), .spi_sclk(sclk), .slave_select_n(ssel_n), .spi_mosi(mosi), .spi_miso_o(miso_o),
		.spi_miso_oe(miso_oe), .host_attention_n(attn_n));

	hspus_host_model hspus_host_model_i (.clk(clk), .uart_din(din), .uart_line(uart_line), .spi_sclk(sclk),
		.slave_select_n(ssel_n), .spi_mosi(mosi), .miso_line(miso_line));

	task automatic report(input string what);
		err_count++;
		$display("[ERR] %0t %s", $time, what);
	endtask : report

	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
			report("bit differs");
	endtask : check_bit

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
			report("byte differs");
	endtask : check_byte

	task automatic check_port(input hspus_port_type got, input hspus_port_type exp);
		check_count++;
		if (got !== exp)
			report("port differs");
	endtask : check_port

	task automatic check_count_val(input int got, input int exp);
		check_count++;
		if (got != exp)
			report("count differs");
	endtask : check_count_val

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic boot(input logic din_low, input logic dout_low, input logic u, input logic s);
		@(posedge clk);
		rst_n <= 1'h0;
		uen <= u;
		sen <= s;
		dout_strap <= dout_low;
		hspus_host_model_i.set_din(~din_low);
		repeat (4) @(posedge clk);
		check_bit(attn_n, 1'h1);
		check_bit(dout_oe | miso_oe, 1'h0);
		@(posedge clk);
		rst_n <= 1'h1;
		repeat (30) @(posedge clk);
		dout_strap <= 1'h0;
		hspus_host_model_i.set_din(1'h1);
		repeat (4) @(posedge clk);
	endtask : boot

	task automatic core_send(input logic [7:0] b);
		int n;
		@(posedge clk);
		tx_data <= b;
		tx_last <= 1'h1;
		tx_valid <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (tx_ready !== 1'h1 && n < 2000);
		tx_valid <= 1'h0;
	endtask : core_send

	task automatic wait_rx(output logic [7:0] b);
		b = 'x;
		for (int n = 0; n < 600; n++)
		begin
			@(posedge clk);
			if (rx_valid === 1'h1)
			begin
				b = rx_data;
				break;
			end
		end
	endtask : wait_rx

	task automatic t_uart();
		logic [7:0] b;
		logic       ok;
		boot(1'h0, 1'h0, 1'h1, 1'h0);
		check_port(port_state, HSPUS_PORT_UART);
		fork
			core_send(8'hA5);
			hspus_host_model_i.uart_recv(b, ok, 16);
		join
		check_byte(b, 8'hA5);
		check_bit(ok, 1'h1);
		fork
			hspus_host_model_i.uart_send(8'h3C, 16);
			wait_rx(b);
		join
		check_byte(b, 8'h3C);
		$display("uart test done");
	endtask : t_uart

	task automatic t_recovery();
		int n;
		boot(1'h1, 1'h0, 1'h0, 1'h0);
		check_bit(cmd, 1'h1);
		check_port(port_state, HSPUS_PORT_UART);
		fork
			core_send(8'hFF);
			hspus_host_model_i.low_span(n);
		join
		check_count_val(n, int'(HSPUS_RECOVERY_DIV));
		$display("recovery test done");
	endtask : t_recovery

	task automatic t_forced();
		logic [7:0] b;
		logic       ok;
		boot(1'h0, 1'h1, 1'h1, 1'h0);
		check_port(port_state, HSPUS_PORT_SPI);
		check_bit(api, HSPUS_API_SPI);
		check_byte({active_pins.attention_pin_function, active_pins.clock_pin_function}, 8'h11);
		check_byte({active_pins.select_pin_function, active_pins.data_in_pin_function}, 8'h11);
		check_byte({4'h0, active_pins.data_out_pin_function}, 8'h01);
		check_bit(attn_n, 1'h1);
		core_send(8'hC3);
		repeat (2) @(posedge clk);
		check_bit(attn_n, 1'h0);
		check_bit(miso_oe, 1'h0);
		hspus_host_model_i.spi_xfer(8'h00, b);
		check_byte(b, 8'hC3);
		repeat (10) @(posedge clk);
		check_bit(attn_n, 1'h1);
		check_bit(miso_oe, 1'h0);
		hspus_host_model_i.spi_xfer(8'h00, b);
		check_byte(b, 8'hFF);
		@(posedge clk);
		save <= 1'h1;
		@(posedge clk);
		save <= 1'h0;
		ok = 1'h0;
		repeat (6)
		begin
			@(posedge clk);
			ok = ok | (strobe === 1'h1);
		end
		check_bit(ok, 1'h1);
		$display("forced spi test done");
	endtask : t_forced

	task automatic t_both();
		logic [7:0] b;
		logic [7:0] m;
		logic       ok;
		boot(1'h0, 1'h0, 1'h0, 1'h1);
		check_port(port_state, HSPUS_PORT_SPI);
		boot(1'h0, 1'h0, 1'h1, 1'h1);
		check_port(port_state, HSPUS_PORT_EITHER);
		fork
			core_send(8'h5A);
			hspus_host_model_i.uart_recv(b, ok, 16);
		join
		check_byte(b, 8'h5A);
		fork
			hspus_host_model_i.spi_xfer(8'h96, m);
			wait_rx(b);
		join
		check_byte(b, 8'h96);
		check_port(port_state, HSPUS_PORT_SPI);
		check_bit(api, 1'h1);
		$display("port choice test done");
	endtask : t_both

	initial
	begin
		t_uart();
		t_recovery();
		t_forced();
		t_both();
		close_out();
	end

	initial
	begin
		#400000;
		err_count++;
		close_out();
	end
endmodule : hspus_port_tb
